// File: verilog/egp_port.sv
`include "egp_cfg.svh"

// Contract
// - Eight pins, each input or output
// - Direction one: driver released, pin input
// - Direction zero: drive pin from latch
// - Read returns pins, write updates latch
// - Port writes go whole into latch, pins not read back
// - Direction controls drivers even on analog
// - Analog pins read zero digitally
// - Open-drain bit: sink only, never high
// - Open-drain clear: push-pull drive
// - Slew-limit bit per pin, limits edges
// - Threshold bit selects Schmitt or TTL
// - Analog bit: reads zero, analog available
// - Analog bits never affect digital output
// - Reset selects analog; software clears bits
module egp_port #(
    parameter int PINS = `EGP_PINS
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // APB slave
    input  wire egp_pkg::egp_apb_req_t apb_req,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Pads: input level, output value, output enable (low drives)
    input  wire logic [PINS-1:0]       pad_in,
    output logic      [PINS-1:0]       pad_out,
    output logic      [PINS-1:0]       pad_oe_n,
    // Pad controls toward the analog and I/O cells
    output logic      [PINS-1:0]       pad_slew_limit,
    output logic      [PINS-1:0]       pad_ttl_select,
    output logic      [PINS-1:0]       pad_analog_en
);

    typedef struct packed {
        egp_pkg::egp_cfg_t cfg;
        logic              ready;
        logic [31:0]       rdata;
        logic              slverr;
        logic [PINS-1:0]   pad_out;
        logic [PINS-1:0]   pad_oe_n;
    } egp_state_t;

    egp_state_t      state_q;
    egp_state_t      state_d;
    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] pin_digital;
    logic            access;

    // Pin levels enter through two flip-flops before any read
    egp_pin_sync #(
        .WIDTH (PINS)
    ) egp_pin_sync_inst (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .raw_in   (pad_in),
        .sync_out (pin_sync)
    );

    // Threshold choice lives in the pad cell; here analog pins read zero
    assign pin_digital = pin_sync & ~state_q.cfg.analog;

    // Answer in the second access cycle, so every transfer has one wait state
    assign access = apb_req.psel & apb_req.penable & ~state_q.ready;

    // Next state: register access and pad drive
    always_comb begin
        state_d        = state_q;
        state_d.ready  = access;
        state_d.slverr = 1'b0;
        state_d.rdata  = '0;
        if (access && apb_req.pwrite) begin
            case (apb_req.paddr)
                `EGP_OFS_PIN_VALUE: begin
                    // Plain write: the whole write data lands in the latch
                    state_d.cfg.latch = apb_req.pwdata[PINS-1:0];
                end
                `EGP_OFS_DIRECTION:  state_d.cfg.direction  = apb_req.pwdata[PINS-1:0];
                `EGP_OFS_LATCH:      state_d.cfg.latch      = apb_req.pwdata[PINS-1:0];
                `EGP_OFS_OPEN_DRAIN: state_d.cfg.open_drain = apb_req.pwdata[PINS-1:0];
                `EGP_OFS_SLEW:       state_d.cfg.slew       = apb_req.pwdata[PINS-1:0];
                `EGP_OFS_THRESHOLD:  state_d.cfg.threshold  = apb_req.pwdata[PINS-1:0];
                `EGP_OFS_ANALOG:     state_d.cfg.analog     = apb_req.pwdata[PINS-1:0];
                default:             state_d.slverr         = 1'b1;
            endcase
        end else if (access) begin
            case (apb_req.paddr)
                `EGP_OFS_PIN_VALUE:  state_d.rdata[PINS-1:0] = pin_digital;
                `EGP_OFS_DIRECTION:  state_d.rdata[PINS-1:0] = state_q.cfg.direction;
                `EGP_OFS_LATCH:      state_d.rdata[PINS-1:0] = state_q.cfg.latch;
                `EGP_OFS_OPEN_DRAIN: state_d.rdata[PINS-1:0] = state_q.cfg.open_drain;
                `EGP_OFS_SLEW:       state_d.rdata[PINS-1:0] = state_q.cfg.slew;
                `EGP_OFS_THRESHOLD:  state_d.rdata[PINS-1:0] = state_q.cfg.threshold;
                `EGP_OFS_ANALOG:     state_d.rdata[PINS-1:0] = state_q.cfg.analog;
                default:             state_d.slverr          = 1'b1;
            endcase
        end
        // Pad drive from the new configuration; analog bits take no part
        for (int i = 0; i < PINS; i++) begin
            // Output only when direction is zero
            // Open drain drives only a low, otherwise push-pull
            state_d.pad_out[i]  = state_d.cfg.latch[i] & ~state_d.cfg.open_drain[i];
            state_d.pad_oe_n[i] = state_d.cfg.direction[i] |
                                  (state_d.cfg.open_drain[i] & state_d.cfg.latch[i]);
        end
    end

    // State register; reset leaves every pin analog and input
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q                <= '0;
            state_q.cfg.direction  <= `EGP_RST_DIRECTION;
            state_q.cfg.latch      <= `EGP_RST_LATCH;
            state_q.cfg.open_drain <= `EGP_RST_OPEN_DRAIN;
            state_q.cfg.slew       <= `EGP_RST_SLEW;
            state_q.cfg.threshold  <= `EGP_RST_THRESHOLD;
            state_q.cfg.analog     <= `EGP_RST_ANALOG;
            state_q.pad_oe_n       <= '1;
        end else begin
            state_q <= state_d;
        end
    end

    // Pad cell controls come straight from state
    assign pad_slew_limit = state_q.cfg.slew;
    assign pad_ttl_select = state_q.cfg.threshold;
    assign pad_analog_en  = state_q.cfg.analog;
    assign pad_out        = state_q.pad_out;
    assign pad_oe_n       = state_q.pad_oe_n;
    assign pready         = state_q.ready;
    assign prdata         = state_q.rdata;
    assign pslverr        = state_q.slverr;

    // Checks on drive and read paths
    input_released_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        ##1 (&state_q.cfg.direction) |-> (&pad_oe_n))
        else $error("input pin driven");

    pushpull_drive_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (!state_q.cfg.direction[0] && !state_q.cfg.open_drain[0])
        |-> (!pad_oe_n[0] && pad_out[0] == state_q.cfg.latch[0]))
        else $error("push-pull pin not driving latch");

    opendrain_high_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (state_q.cfg.open_drain[0] && state_q.cfg.latch[0]) |-> pad_oe_n[0])
        else $error("open-drain pin driven high");

    analog_reads_zero_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_PIN_VALUE
         && state_q.cfg.analog[0]) |=> (pready && prdata[0] == 1'b0))
        else $error("analog pin read nonzero");

    write_to_latch_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && apb_req.pwrite && apb_req.paddr == `EGP_OFS_PIN_VALUE)
        |=> (state_q.cfg.latch == $past(apb_req.pwdata[PINS-1:0])))
        else $error("port write missed latch");

    pin_sampled_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        ##3 (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_PIN_VALUE
         && !state_q.cfg.analog[1]) |=> (prdata[1] == $past(pad_in[1], 3)))
        else $error("pin read not two-stage sampled");

    answer_one_cycle_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (apb_req.psel && apb_req.penable && !pready) |=> pready)
        else $error("apb answer late");

    slew_follows_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && apb_req.pwrite && apb_req.paddr == `EGP_OFS_SLEW)
        |=> (pad_slew_limit == $past(apb_req.pwdata[PINS-1:0])))
        else $error("slew select not applied");

    // Answer shape: one-cycle pulse, error and data only alongside it
    ready_pulse_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        pready |=> !pready)
        else $error("apb ready held too long");

    error_with_ready_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        pslverr |-> pready)
        else $error("apb error without ready");

    data_idle_zero_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !pready |-> (prdata == 32'h0))
        else $error("read data outside answer");

    data_upper_zero_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        pready |-> ((prdata >> PINS) == 32'h0))
        else $error("read data beyond port width");

    unmapped_error_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && !(apb_req.paddr inside {`EGP_OFS_PIN_VALUE, `EGP_OFS_DIRECTION,
            `EGP_OFS_LATCH, `EGP_OFS_OPEN_DRAIN, `EGP_OFS_SLEW, `EGP_OFS_THRESHOLD,
            `EGP_OFS_ANALOG})) |=> (pready && pslverr))
        else $error("unmapped access not refused");

    mapped_no_error_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && (apb_req.paddr inside {`EGP_OFS_PIN_VALUE, `EGP_OFS_DIRECTION,
            `EGP_OFS_LATCH, `EGP_OFS_OPEN_DRAIN, `EGP_OFS_SLEW, `EGP_OFS_THRESHOLD,
            `EGP_OFS_ANALOG})) |=> (pready && !pslverr))
        else $error("mapped access refused");

    // Configuration moves only on a write, and a write lands whole
    cfg_holds_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !(access && apb_req.pwrite) |=> $stable(state_q.cfg))
        else $error("configuration changed without a write");

    direction_follows_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && apb_req.pwrite && apb_req.paddr == `EGP_OFS_DIRECTION)
        |=> (state_q.cfg.direction == $past(apb_req.pwdata[PINS-1:0])))
        else $error("direction write missed");

    latch_follows_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && apb_req.pwrite && apb_req.paddr == `EGP_OFS_LATCH)
        |=> (state_q.cfg.latch == $past(apb_req.pwdata[PINS-1:0])))
        else $error("latch write missed");

    threshold_follows_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && apb_req.pwrite && apb_req.paddr == `EGP_OFS_THRESHOLD)
        |=> (pad_ttl_select == $past(apb_req.pwdata[PINS-1:0])))
        else $error("threshold select not applied");

    analog_follows_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && apb_req.pwrite && apb_req.paddr == `EGP_OFS_ANALOG)
        |=> (pad_analog_en == $past(apb_req.pwdata[PINS-1:0])))
        else $error("analog select not applied");

    // Every register except threshold is checked to read back what it holds
    direction_readback_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_DIRECTION)
        |=> (prdata[PINS-1:0] == $past(state_q.cfg.direction)))
        else $error("direction read back wrong");

    latch_readback_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_LATCH)
        |=> (prdata[PINS-1:0] == $past(state_q.cfg.latch)))
        else $error("latch read back wrong");

    opendrain_readback_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_OPEN_DRAIN)
        |=> (prdata[PINS-1:0] == $past(state_q.cfg.open_drain)))
        else $error("open-drain select read back wrong");

    slew_readback_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_SLEW)
        |=> (prdata[PINS-1:0] == $past(state_q.cfg.slew)))
        else $error("slew select read back wrong");

    analog_readback_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_ANALOG)
        |=> (prdata[PINS-1:0] == $past(state_q.cfg.analog)))
        else $error("analog select read back wrong");

    reset_defaults_a : assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        $rose(reset_n) |-> (state_q.cfg.analog == `EGP_RST_ANALOG
            && state_q.cfg.direction == `EGP_RST_DIRECTION && (&pad_oe_n)))
        else $error("reset left a pin digital or driven");

    // Every pin alike; analog selection never touches the drivers
    for (genvar p = 0; p < PINS; p++) begin : g_pin_chk
        pin_release_a : assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            state_q.cfg.direction[p] |-> pad_oe_n[p])
            else $error("released pin driven");

        pin_drive_a : assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            (!state_q.cfg.direction[p] && !state_q.cfg.open_drain[p])
            |-> (!pad_oe_n[p] && pad_out[p] == state_q.cfg.latch[p]))
            else $error("output pin not driving latch");

        pin_sink_a : assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            (!state_q.cfg.direction[p] && state_q.cfg.open_drain[p] && !state_q.cfg.latch[p])
            |-> (!pad_oe_n[p] && !pad_out[p]))
            else $error("open-drain pin not sinking");

        pin_never_high_a : assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            (state_q.cfg.open_drain[p] && !pad_oe_n[p]) |-> !pad_out[p])
            else $error("open-drain pin sourcing");

        analog_output_a : assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            (state_q.cfg.analog[p] && !state_q.cfg.direction[p] && !state_q.cfg.open_drain[p])
            |-> (!pad_oe_n[p] && pad_out[p] == state_q.cfg.latch[p]))
            else $error("analog output pin not driving");

        pin_read_a : assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            (access && !apb_req.pwrite && apb_req.paddr == `EGP_OFS_PIN_VALUE)
            |=> (prdata[p] == ($past(pin_sync[p]) & ~$past(state_q.cfg.analog[p]))))
            else $error("pin read value wrong");
    end

endmodule : egp_port

// File: inc/egp_cfg.svh
`ifndef EGP_CFG_SVH
`define EGP_CFG_SVH

// Register byte offsets on the APB slave
`define EGP_OFS_PIN_VALUE   12'h000
`define EGP_OFS_DIRECTION   12'h004
`define EGP_OFS_LATCH       12'h008
`define EGP_OFS_OPEN_DRAIN  12'h00C
`define EGP_OFS_SLEW        12'h010
`define EGP_OFS_THRESHOLD   12'h014
`define EGP_OFS_ANALOG      12'h018

// Reset values
`define EGP_RST_DIRECTION   8'hFF
`define EGP_RST_LATCH       8'h00
`define EGP_RST_OPEN_DRAIN  8'h00
`define EGP_RST_SLEW        8'h00
`define EGP_RST_THRESHOLD   8'h00
`define EGP_RST_ANALOG      8'hFF

// Port geometry
`define EGP_PINS            8
`define EGP_ADDR_W          12

`endif

// File: inc/egp_pkg.sv
package egp_pkg;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } egp_apb_req_t;

    // Per-pin configuration set
    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] latch;
        logic [7:0] open_drain;
        logic [7:0] slew;
        logic [7:0] threshold;
        logic [7:0] analog;
    } egp_cfg_t;

endpackage : egp_pkg

// File: verilog/egp_pin_sync.sv
`include "egp_cfg.svh"

// Two-stage synchroniser for the raw pin levels, one per pin
module egp_pin_sync #(
    parameter int WIDTH = `EGP_PINS
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } egp_sync_state_t;

    egp_sync_state_t state_q;
    egp_sync_state_t state_d;

    // Stage one is read only by stage two
    always_comb begin
        state_d        = state_q;
        state_d.stage1 = raw_in;
        state_d.stage2 = state_q.stage1;
    end

    // Register the synchroniser chain
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stage2;

endmodule : egp_pin_sync

// File: verif/egp_board.sv
// Board circuitry on the port pins: it imposes a level on every released pin
module egp_board (
    // Device side of the pads
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe_n,
    // Level that the board puts on pins the device does not drive
    input  wire logic [7:0] ext_level,
    // Resolved level seen by the pad input buffers
    output logic      [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // A driven pin follows the device, so loopback reads show the latch on non-analog pins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = pad_oe_n[i] ? ext_level[i] : pad_out[i];
        end
    end
endmodule : egp_board

// File: verif/eight_bit_gpio_port_tb.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

module eight_bit_gpio_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  sys_clk, reset_n, pready, pslverr, err;
    egp_pkg::egp_apb_req_t req;
    logic [31:0]           prdata, rd, wd;
    logic [7:0]            pad_in, pad_out, pad_oe_n, slew, ttl, ana, ext_level;
    logic [7:0]            m [7];
    int                    n_errors, checked, cycles, k;

    egp_port egp_port_inst (.sys_clk(sys_clk), .reset_n(reset_n), .apb_req(req),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_slew_limit(slew),
        .pad_ttl_select(ttl), .pad_analog_en(ana));
    egp_board egp_board_inst (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .ext_level(ext_level), .pad_in(pad_in));

    // 5 ns period
    always #2.5 sys_clk = ~sys_clk;

    // Hang guard, well above the expected run of about 1200 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task test_done();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // One APB transfer; waits for pready without assuming a latency
    task apb(input logic wr, input int idx, input logic [31:0] data);
        req.psel    <= 1'b1;
        req.pwrite  <= wr;
        req.paddr   <= 12'(idx * 4);
        req.pwdata  <= data;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // Ends when pready is seen high; the hang guard ends it if pready never rises
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // Pad controls against the model registers
    task chk_pads();
        logic [7:0] oe;
        oe = m[1] | (m[3] & m[2]);
        `CHK(pad_oe_n, oe)
        `CHK(pad_out, m[2] & ~m[3])
        `CHK(slew, m[4])
        `CHK(ttl, m[5])
        `CHK(ana, m[6])
    endtask : chk_pads

    // Every register read back; pins given time to pass the synchroniser
    task chk_regs();
        logic [7:0] oe, lvl;
        repeat (4) @(posedge sys_clk);
        oe = m[1] | (m[3] & m[2]);
        lvl = (oe & ext_level) | (~oe & m[2] & ~m[3]);
        for (int j = 0; j < 7; j++) begin
            apb(1'b0, j, 32'h0);
            `CHK(rd, {24'h0, j == 0 ? lvl & ~m[6] : m[j]})
            `CHK(err, 1'b0)
        end
    endtask : chk_regs

    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        req = '0;
        ext_level = 8'h00;
        rd = $urandom(40087);
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Second pass starts from a reset taken in mid-run
        for (int r = 0; r < 2; r++) begin
            m = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
            chk_pads();
            chk_regs();
            apb(1'b1, 7, $urandom);
            `CHK(err, 1'b1)
            apb(1'b0, 7, 32'h0);
            `CHK({err, rd}, {1'b1, 32'h0})
            // Random writes to any of the seven registers, each with a new external level
            for (int i = 0; i < 60; i++) begin
                k = $urandom_range(6, 0);
                wd = $urandom;
                // Second pass behaves like careful software: analog pins stay inputs
                if (r == 1 && k == 1)
                    wd[7:0] = wd[7:0] | m[6];
                if (r == 1 && k == 6)
                    wd[7:0] = wd[7:0] & m[1];
                ext_level <= 8'($urandom);
                apb(1'b1, k, wd);
                m[k == 0 ? 2 : k] = wd[7:0];
                chk_pads();
                if (i % 6 == 5)
                    chk_regs();
            end
            reset_n <= 1'b0;
            repeat (3) @(posedge sys_clk);
            reset_n <= 1'b1;
        end
        test_done();
    end
endmodule : eight_bit_gpio_port_tb
